// ===== verilog/bwm_pkg.sv
package bwm_pkg;

	// bus sequencer states
	typedef enum logic [2:0] {
		BWM_IDLE,
		BWM_ADDR,
		BWM_HOLD,
		BWM_RD0,
		BWM_RD1,
		BWM_WRITE
	} bwm_state_t;

	// register byte offsets on the wishbone bus
	localparam logic [7:0] OFS_PIN_LEVEL = 8'h00;
	localparam logic [7:0] OFS_OUT_LATCH = 8'h04;
	localparam logic [7:0] OFS_DIRECTION = 8'h08;
	localparam logic [7:0] OFS_CTRL      = 8'h0c;
	localparam logic [7:0] OFS_TBL_PTR   = 8'h10;
	localparam logic [7:0] OFS_TBL_LATCH = 8'h14;
	localparam logic [7:0] OFS_CMD       = 8'h18;
	localparam logic [7:0] OFS_STATUS    = 8'h1c;

	// field positions
	localparam int CTRL_BUS_EN_BIT  = 0;
	localparam int CTRL_PSP_EN_BIT  = 1;
	localparam int CMD_FETCH_BIT    = 0;
	localparam int CMD_TABLE_WRITE_OP_BIT    = 1;
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_DONE_BIT    = 1;
	localparam int STAT_WORD_LSB    = 16;

	// reset values
	localparam logic [7:0]  RST_OUT_LATCH = 8'h00;
	localparam logic [7:0]  RST_DIRECTION = 8'hff;
	localparam logic [1:0]  RST_CTRL      = 2'h0;
	localparam logic [15:0] RST_TBL_PTR   = 16'h0000;
	localparam logic [7:0]  RST_TBL_LATCH = 8'h00;

	// timing: one instruction cycle and its phases
	localparam int CLK_NS       = 50;
	localparam int TCY_NS       = 800;
	localparam int TCY_CYC      = TCY_NS / CLK_NS;
	localparam int ADDR_CYC     = 2;
	localparam int HOLD_CYC     = 2;
	localparam int BYTE_CYC     = (TCY_CYC - ADDR_CYC - HOLD_CYC) / 2;
	localparam logic [3:0] ADDR_LAST  = 4'(ADDR_CYC - 1);
	localparam logic [3:0] HOLD_LAST  = 4'(HOLD_CYC - 1);
	localparam logic [3:0] BYTE_LAST  = 4'(BYTE_CYC - 1);
	localparam logic [3:0] WRITE_LAST = 4'(2 * BYTE_CYC - 1);

	// external memory bus pin drive
	typedef struct packed {
		logic [15:0] ad;
		logic [15:0] ad_oe;
		logic        ale;
		logic        oe_n;
		logic        we_n;
		logic        ce_n;
		logic        byte_select;
	} bwm_pins_t;

endpackage

// ===== verilog/bwm_sync3.sv
`timescale 1ns/1ns
module bwm_sync3 #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// asynchronous pins in, filtered level out
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o
);

	// whole state of the filter
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} bwm_sync_t;

	bwm_sync_t        sync_r;
	bwm_sync_t        sync_nxt;

	assign level_o = sync_r.level;

	// three stages; a bit changes only once stages two and three agree
	always_comb begin
		sync_nxt    = sync_r;
		sync_nxt.s1 = pin_i;
		sync_nxt.s2 = sync_r.s1;
		sync_nxt.s3 = sync_r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (sync_r.s2[i] == sync_r.s3[i]) begin
				sync_nxt.level[i] = sync_r.s3[i];
			end
		end
	end

	// one register for the whole filter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_r <= '0;
		end else begin
			sync_r <= sync_nxt;
		end
	end

endmodule // bwm_sync3

// ===== verilog/bwm_ext_bus.sv
// Functional notes
// - In byte mode read data travels only on the low eight lines of the shared address/data bus.
// - An instruction is fetched as two successive byte reads inside one instruction cycle.
// - The address latch strobe is high while the sixteen shared lines carry a valid address.
// - The read strobe enables one byte, then byte select flips and the second byte completes a 16-bit word.
// - Chip select is held low throughout every external read and write access, except while the device sleeps mid-access.
// - Chip select is held high while the device sleeps.
// - A table write drives the table latch byte on both the upper and lower bus halves.
// - A table write sets byte select to the low bit of the table pointer.
// - A pin owned by the bus or the parallel slave port takes its direction from that function, not its direction bit.
// - Memory bus use of a shared pin overrides port and parallel slave port use.
// - Parallel slave port read data drives the output latch value and beats ordinary port output.
`timescale 1ns/1ns
module bwm_ext_bus (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// core side controls
	input  wire logic                sleep_i,
	input  wire logic                psp_read_i,
	// shared address/data pins
	input  wire logic [15:0]         ad_i,
	output bwm_pkg::bwm_pins_t       bus_pins_o
);

	import bwm_pkg::*;

	// whole state of the block
	typedef struct packed {
		bwm_state_t  state;
		logic [3:0]  cnt;
		logic        is_write;
		logic        ack;
		logic [31:0] dat;
		logic [7:0]  out_latch;
		logic [7:0]  direction;
		logic [1:0]  ctrl;
		logic [15:0] tbl_ptr;
		logic [7:0]  tbl_latch;
		logic [15:0] word;
		logic        done;
		bwm_pins_t   pins;
	} bwm_regs_t;

	bwm_regs_t   r;
	bwm_regs_t   r_nxt;
	logic [15:0] ad_level;

	// pins are asynchronous to clk_i
	bwm_sync3 #(
		.WIDTH   (16)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   (ad_i),
		.level_o (ad_level)
	);

	// merge write data into a register by wishbone byte lanes
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// read view of every mapped register except the write-only command register, zero elsewhere
	function automatic logic [31:0] read_mux(input bwm_regs_t s,
		input logic [7:0] adr, input logic [7:0] pins);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (adr)
			OFS_PIN_LEVEL: v[7:0]  = pins;
			OFS_OUT_LATCH: v[7:0]  = s.out_latch;
			OFS_DIRECTION: v[7:0]  = s.direction;
			OFS_CTRL:      v[1:0]  = s.ctrl;
			OFS_TBL_PTR:   v[15:0] = s.tbl_ptr;
			OFS_TBL_LATCH: v[7:0]  = s.tbl_latch;
			OFS_STATUS: begin
				v[STAT_BUSY_BIT]               = (s.state != BWM_IDLE);
				v[STAT_DONE_BIT]               = s.done;
				v[STAT_WORD_LSB +: 16]         = s.word;
			end
			default:       v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// outputs come straight from the state flops
	assign wb_ack_o   = r.ack;
	assign wb_dat_o   = r.dat;
	assign bus_pins_o = r.pins;

	// next state of the whole block
	always_comb begin
		logic        wr_hit;
		logic [31:0] wmerged;
		logic        start_fetch;
		logic        start_table_write_op;
		logic        clear_done;
		logic        set_done;
		logic        bus_owns;
		logic [31:0] ptr_merged;
		// every field holds unless a branch below moves it
		r_nxt       = r;
		wr_hit      = 1'b0;
		wmerged     = 32'h0000_0000;
		start_fetch = 1'b0;
		start_table_write_op = 1'b0;
		clear_done  = 1'b0;
		set_done    = 1'b0;
		bus_owns    = 1'b0;
		ptr_merged  = 32'h0000_0000;

		// single cycle answer; ack drops the cycle after it is given
		r_nxt.ack = wb_cyc_i & wb_stb_i & ~r.ack;
		if (wb_cyc_i && wb_stb_i && !r.ack) begin
			r_nxt.dat = read_mux(r, wb_adr_i, ad_level[7:0]);
		end

		// writes take effect on the edge where ack is seen high
		wr_hit  = wb_cyc_i & wb_stb_i & wb_we_i & r.ack;
		wmerged = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
		if (wr_hit) begin
			unique case (wb_adr_i)
				// writing the pin level register lands in the latch
				OFS_PIN_LEVEL, OFS_OUT_LATCH: begin
					if (wb_sel_i[0]) begin
						r_nxt.out_latch = wmerged[7:0];
					end
				end
				OFS_DIRECTION: begin
					if (wb_sel_i[0]) begin
						r_nxt.direction = wmerged[7:0];
					end
				end
				OFS_CTRL: begin
					if (wb_sel_i[0]) begin
						r_nxt.ctrl = wmerged[1:0];
					end
				end
				// the pointer takes lanes 0 and 1 only
				OFS_TBL_PTR: begin
					ptr_merged    = lane_merge({16'h0000, r.tbl_ptr}, wb_dat_i,
						wb_sel_i);
					r_nxt.tbl_ptr = ptr_merged[15:0];
				end
				OFS_TBL_LATCH: begin
					if (wb_sel_i[0]) begin
						r_nxt.tbl_latch = wmerged[7:0];
					end
				end
				OFS_CMD: begin
					start_fetch = wmerged[CMD_FETCH_BIT];
					start_table_write_op = wmerged[CMD_TABLE_WRITE_OP_BIT] & ~wmerged[CMD_FETCH_BIT];
				end
				OFS_STATUS: begin
					clear_done = wmerged[STAT_DONE_BIT];
				end
				default: begin
				end
			endcase
		end

		// bus sequencer, one instruction cycle per access
		unique case (r.state)
			BWM_IDLE: begin
				// commands while asleep or with the bus off are dropped
				if ((start_fetch || start_table_write_op) && r.ctrl[CTRL_BUS_EN_BIT] && !sleep_i) begin
					r_nxt.state    = BWM_ADDR;
					r_nxt.cnt      = ADDR_LAST;
					r_nxt.is_write = start_table_write_op;
					r_nxt.pins.ce_n = 1'b0;
					r_nxt.pins.ale   = 1'b1;
					r_nxt.pins.ad    = start_table_write_op ? r.tbl_ptr : {r.tbl_ptr[15:1], 1'b0};
					r_nxt.pins.ad_oe = 16'hffff;
					r_nxt.pins.byte_select = 1'b0;
				end
			end
			BWM_ADDR: begin
				r_nxt.cnt = r.cnt - 4'h1;
				if (r.cnt == 4'h0) begin
					r_nxt.pins.ale = 1'b0;
					r_nxt.state    = BWM_HOLD;
					r_nxt.cnt      = HOLD_LAST;
				end
			end
			BWM_HOLD: begin
				// address stays on the lines while the latch closes
				r_nxt.cnt = r.cnt - 4'h1;
				if (r.cnt == 4'h0) begin
					if (r.is_write) begin
						r_nxt.state = BWM_WRITE;
						r_nxt.cnt   = WRITE_LAST;
						r_nxt.pins.ad = {r.tbl_latch, r.tbl_latch};
						r_nxt.pins.byte_select = r.tbl_ptr[0];
						r_nxt.pins.we_n        = 1'b0;
					end else begin
						r_nxt.state = BWM_RD0;
						r_nxt.cnt   = BYTE_LAST;
						r_nxt.pins.ad_oe       = 16'h0000;
						r_nxt.pins.oe_n        = 1'b0;
						r_nxt.pins.byte_select = 1'b0;
					end
				end
			end
			BWM_RD0: begin
				r_nxt.cnt = r.cnt - 4'h1;
				if (r.cnt == 4'h0) begin
					r_nxt.word[7:0] = ad_level[7:0];
					r_nxt.pins.byte_select = 1'b1;
					r_nxt.state = BWM_RD1;
					r_nxt.cnt   = BYTE_LAST;
				end
			end
			BWM_RD1: begin
				r_nxt.cnt = r.cnt - 4'h1;
				if (r.cnt == 4'h0) begin
					r_nxt.word[15:8]       = ad_level[7:0];
					r_nxt.pins.oe_n        = 1'b1;
					r_nxt.pins.ce_n        = 1'b1;
					r_nxt.pins.byte_select = 1'b0;
					r_nxt.state            = BWM_IDLE;
					set_done               = 1'b1;
				end
			end
			BWM_WRITE: begin
				r_nxt.cnt = r.cnt - 4'h1;
				if (r.cnt == 4'h0) begin
					r_nxt.pins.we_n        = 1'b1;
					r_nxt.pins.ce_n        = 1'b1;
					r_nxt.pins.ad_oe       = 16'h0000;
					r_nxt.pins.byte_select = 1'b0;
					r_nxt.state            = BWM_IDLE;
					set_done               = 1'b1;
				end
			end
			// an unused code drops every strobe and returns to idle
			default: begin
				r_nxt.state            = BWM_IDLE;
				r_nxt.cnt              = 4'h0;
				r_nxt.pins.ale         = 1'b0;
				r_nxt.pins.oe_n        = 1'b1;
				r_nxt.pins.we_n        = 1'b1;
				r_nxt.pins.ce_n        = 1'b1;
				r_nxt.pins.ad_oe       = 16'h0000;
				r_nxt.pins.byte_select = 1'b0;
			end
		endcase

		// completion flag: a finishing access beats a software clear
		if (clear_done) begin
			r_nxt.done = 1'b0;
		end
		if (set_done) begin
			r_nxt.done = 1'b1;
		end

		// bus owns the pins over port and slave port
		bus_owns = r.ctrl[CTRL_BUS_EN_BIT] | (r.state != BWM_IDLE);
		if (!bus_owns) begin
			// upper lines carry nothing outside the bus function
			r_nxt.pins.ad[15:8]    = 8'h00;
			r_nxt.pins.ad_oe[15:8] = 8'h00;
			for (int i = 0; i < 8; i++) begin
				if (r.ctrl[CTRL_PSP_EN_BIT]) begin
					// slave port read data from latch
					r_nxt.pins.ad[i]    = r.out_latch[i];
					r_nxt.pins.ad_oe[i] = psp_read_i;
				end else begin
					// plain port: direction bit high means input
					r_nxt.pins.ad[i]    = r.out_latch[i];
					r_nxt.pins.ad_oe[i] = ~r.direction[i];
				end
			end
		end else if (r.state == BWM_IDLE && r_nxt.state == BWM_IDLE) begin
			// idle bus lines float whatever the direction bits
			r_nxt.pins.ad_oe = 16'h0000;
		end

		if (sleep_i) begin
			r_nxt.pins.ce_n = 1'b1;
		end else if (r_nxt.state != BWM_IDLE) begin
			// an access that outlives a sleep must not finish deselected
			r_nxt.pins.ce_n = 1'b0;
		end
	end

	// the single register process; a sleep mid-access only drops select
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r.state            <= BWM_IDLE;
			r.cnt              <= 4'h0;
			r.is_write         <= 1'b0;
			r.ack              <= 1'b0;
			r.dat              <= 32'h0000_0000;
			r.out_latch        <= RST_OUT_LATCH;
			r.direction        <= RST_DIRECTION;
			r.ctrl             <= RST_CTRL;
			r.tbl_ptr          <= RST_TBL_PTR;
			r.tbl_latch        <= RST_TBL_LATCH;
			r.word             <= 16'h0000;
			r.done             <= 1'b0;
			r.pins.ad          <= 16'h0000;
			r.pins.ad_oe       <= 16'h0000;
			r.pins.ale         <= 1'b0;
			r.pins.oe_n        <= 1'b1;
			r.pins.we_n        <= 1'b1;
			r.pins.ce_n        <= 1'b1;
			r.pins.byte_select <= 1'b0;
		end else begin
			r <= r_nxt;
		end
	end

endmodule // bwm_ext_bus

// ===== tb/bwm_ext_bus_assertions.sv
`timescale 1ns/1ns
module bwm_ext_bus_chk (
	// clock and reset
	input wire logic               clk_i,
	input wire logic               rst_i,
	// core side and memory pins
	input wire logic               sleep_i,
	input wire bwm_pkg::bwm_pins_t bus_pins_o
);
	import bwm_pkg::*;
	bwm_pins_t p;
	assign p = bus_pins_o;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// address phase, then a quiet gap so the latch settles before data
	sequence s_addr;
		p.ale[*2] ##1 (!p.ale && p.oe_n && p.we_n)[*2];
	endsequence
	// low byte first, then the high byte
	sequence s_rd;
		(!p.oe_n && !p.byte_select)[*6] ##1 (!p.oe_n && p.byte_select)[*6];
	endsequence
	// byte select must not move mid write
	sequence s_wr;
		(!p.we_n)[*6] ##1 (!p.we_n && $stable(p.byte_select))[*6];
	endsequence

	property p_addr; $rose(p.ale) |-> s_addr; endproperty
	property p_ale_drive; p.ale |-> p.ad_oe == 16'hffff && p.oe_n && p.we_n; endproperty
	property p_fetch; $fell(p.oe_n) |-> s_rd ##1 p.oe_n; endproperty
	property p_rd_float; !p.oe_n |-> p.ad_oe == 16'h0000; endproperty
	property p_ce_acc; (!p.oe_n || !p.we_n) && !$past(sleep_i) |-> !p.ce_n; endproperty
	property p_sleep; sleep_i |=> p.ce_n; endproperty
	property p_wr_dup; !p.we_n |-> p.ad[15:8] == p.ad[7:0] && p.ad_oe == 16'hffff; endproperty
	property p_wr_len; $fell(p.we_n) |-> s_wr ##1 p.we_n; endproperty

	a_addr: assert property (p_addr)
		else $error("latch strobe phase malformed");
	a_ale_drive: assert property (p_ale_drive)
		else $error("address not driven under latch strobe");
	a_fetch: assert property (p_fetch)
		else $error("fetch byte phases malformed");
	a_rd_float: assert property (p_rd_float)
		else $error("lines driven during read strobe");
	a_ce_acc: assert property (p_ce_acc)
		else $error("chip select high during access");
	a_sleep: assert property (p_sleep)
		else $error("chip select low while asleep");
	a_wr_dup: assert property (p_wr_dup)
		else $error("table write halves differ");
	a_wr_len: assert property (p_wr_len)
		else $error("table write strobe malformed");
endmodule // bwm_ext_bus_chk

bind bwm_ext_bus bwm_ext_bus_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep_i),
	.bus_pins_o(bus_pins_o));

// ===== tb/bwm_mem_model.sv
`timescale 1ns/1ns
module bwm_mem_model (
	// clock
	input  wire logic               clk_i,
	// device pins and board drive of the port lines
	input  wire bwm_pkg::bwm_pins_t pins_i,
	input  wire logic [7:0]         ext_i,
	// resolved line levels
	output logic      [15:0]        ad_o
);
	import bwm_pkg::*;
	logic [7:0]  mem [256];
	logic [15:0] addr_r;
	logic [15:0] far_v;
	logic        nz_r;
	logic [7:0]  idx;

	// byte select wired as low address bit
	assign idx = {addr_r[7:1], pins_i.byte_select};

	initial begin
		nz_r = 1'b0;
		addr_r = 16'h0000;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
	end

	// external latch follows the lines while the strobe is high
	always @(posedge clk_i) begin
		nz_r <= ~nz_r;
		if (pins_i.ale) addr_r <= ad_o;
		if (!pins_i.we_n && !pins_i.ce_n) mem[idx] <= ad_o[7:0];
	end

	// released lines toggle so stale data never passes for valid
	always_comb begin
		far_v = nz_r ? 16'h5aa5 : 16'ha55a;
		if (pins_i.ce_n) far_v[7:0] = ext_i;
		else if (!pins_i.oe_n) far_v[7:0] = mem[idx];
	end
	// device drive wins wherever enabled
	assign ad_o = (pins_i.ad & pins_i.ad_oe) | (far_v & ~pins_i.ad_oe);
endmodule // bwm_mem_model

// ===== tb/tb_byte_wide_ext_mem_bus.sv
`timescale 1ns/1ns
module tb_byte_wide_ext_mem_bus;
	import bwm_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, sleep_i, psp_read_i, ack;
	logic [7:0]  adr, ext;
	logic [31:0] dat, rdat, q;
	logic [15:0] ad;
	bwm_pins_t   pins;
	int          fail_count, checks_done;

	bwm_ext_bus i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .sleep_i(sleep_i), .psp_read_i(psp_read_i), .ad_i(ad),
		.bus_pins_o(pins));
	bwm_mem_model i_mem (.clk_i(clk_i), .pins_i(pins), .ext_i(ext), .ad_o(ad));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; request held until ack is seen at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = rdat;
		{cyc, stb, we} <= 3'h0;
		// a slave that never answers counts as a mismatch
		if (ack !== 1'b1) begin
			chk(32'(ack), 32'h1);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// poll status, bounded so a lost sequence cannot hang
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			wb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (q[STAT_DONE_BIT] !== 1'b1 && n < 20);
		if (q[STAT_DONE_BIT] !== 1'b1) begin
			chk(32'(q[STAT_DONE_BIT]), 32'h1);
		end
	endtask
	function automatic logic [7:0] mv(input logic [7:0] i);
		return i ^ 8'h3c;
	endfunction

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		tick(20000);
		fail_count++;
		stop_test();
	end

	initial begin
		{cyc, stb, we, adr, dat, sleep_i, psp_read_i} = '0;
		ext = 8'h3c;
		fail_count = 0;
		checks_done = 0;
		rst_i = 1'b1;
		tick(5);
		rst_i <= 1'b0;
		// reset values and an unmapped place
		rd(OFS_DIRECTION, 32'hff);
		rd(OFS_OUT_LATCH, 32'h0);
		rd(OFS_CTRL, 32'h0);
		rd(8'h20, 32'h0);
		// a command with the bus disabled is dropped
		wb(1'b1, OFS_CMD, 32'h1);
		rd(OFS_STATUS, 32'h0);
		// port mode: direction picks driven bits, the rest read the board
		wb(1'b1, OFS_OUT_LATCH, 32'ha5);
		wb(1'b1, OFS_DIRECTION, 32'h0f);
		tick(8);
		chk(32'(pins.ad_oe), 32'hf0);
		rd(OFS_PIN_LEVEL, 32'hac);
		// slave port read overrides the direction bits
		wb(1'b1, OFS_CTRL, 32'h2);
		psp_read_i <= 1'b1;
		tick(2);
		chk({pins.ad_oe, 8'h0, pins.ad[7:0]}, 32'h00ff00a5);
		psp_read_i <= 1'b0;
		tick(2);
		chk(32'(pins.ad_oe), 32'h0);
		// bus owns the lines even with a slave read pending
		wb(1'b1, OFS_CTRL, 32'h3);
		psp_read_i <= 1'b1;
		tick(2);
		chk(32'(pins.ad_oe), 32'h0);
		wb(1'b1, OFS_TBL_PTR, 32'h43);
		wb(1'b1, OFS_CMD, 32'h1);
		wait_done();
		chk(q, {mv(8'h43), mv(8'h42), 16'h2});
		wb(1'b1, OFS_STATUS, 32'h2);
		rd(OFS_STATUS, {mv(8'h43), mv(8'h42), 16'h0});
		// table write to an odd address
		wb(1'b1, OFS_TBL_LATCH, 32'h96);
		wb(1'b1, OFS_TBL_PTR, 32'h11);
		wb(1'b1, OFS_CMD, 32'h2);
		tick(8);
		chk({pins.ad, pins.we_n, pins.ce_n, 13'h0, pins.byte_select}, 32'h96960001);
		wait_done();
		chk(32'(i_mem.mem[8'h11]), 32'h96);
		chk(32'(i_mem.mem[8'h10]), 32'(mv(8'h10)));
		// sleep mid fetch drops chip select while the sequence runs on
		wb(1'b1, OFS_STATUS, 32'h2);
		wb(1'b1, OFS_CMD, 32'h1);
		tick(6);
		sleep_i <= 1'b1;
		tick(2);
		chk(32'(pins.ce_n), 32'h1);
		sleep_i <= 1'b0;
		tick(2);
		chk(32'(pins.ce_n), 32'h0);
		wait_done();
		chk(32'(q[STAT_DONE_BIT]), 32'h1);
		stop_test();
	end
endmodule // tb_byte_wide_ext_mem_bus
